// File: pbm_pkg.sv
// Package for the port B / port C pin function mux
package pbm_pkg;
   // Port output modes, two bits per pin
   typedef enum logic [1:0] {
      PBM_MODE_QUASI  = 2'b00,
      PBM_MODE_PUSH   = 2'b01,
      PBM_MODE_INPUT  = 2'b10,
      PBM_MODE_OPEN   = 2'b11
   } pbm_mode_t;

   // Processor clock sources
   typedef enum logic [1:0] {
      PBM_CLK_RC      = 2'b00,
      PBM_CLK_WDOG    = 2'b01,
      PBM_CLK_EXT     = 2'b10,
      PBM_CLK_XTAL    = 2'b11
   } pbm_clksrc_t;

   localparam int        PBM_B_WIDTH       = 8;
   localparam int        PBM_C_WIDTH       = 2;
   localparam logic [1:0] PBM_MODE_RESET   = 2'h2;
   localparam logic [7:0] PBM_TRIM_RESET   = 8'h00;
   localparam int        PBM_TRIM_CLKEN    = 6;

   // Register index map
   localparam logic [3:0] PBM_A_B_OUT      = 4'h0;
   localparam logic [3:0] PBM_A_B_M1       = 4'h1;
   localparam logic [3:0] PBM_A_B_M2       = 4'h2;
   localparam logic [3:0] PBM_A_C_OUT      = 4'h3;
   localparam logic [3:0] PBM_A_C_MODE     = 4'h4;
   localparam logic [3:0] PBM_A_TRIM       = 4'h5;
   localparam logic [3:0] PBM_A_SPI        = 4'h6;
   localparam logic [3:0] PBM_A_CLK        = 4'h7;
   localparam logic [3:0] PBM_A_B_IN       = 4'h8;
   localparam logic [3:0] PBM_A_C_IN       = 4'h9;
endpackage : pbm_pkg

// File: pbm_pin_mux.sv
// Pin function mux for port B (8 bits) and port C (2 bits)
`timescale 1ns/1ps
module pbm_pin_mux
   import pbm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic [7:0]  port_b_i,
   output logic      [7:0]  port_b_o,
   output logic      [7:0]  port_b_oe_o,
   output logic      [7:0]  port_b_pu_o,
   input  wire logic [1:0]  port_c_i,
   output logic      [1:0]  port_c_o,
   output logic      [1:0]  port_c_oe_o,
   output logic      [1:0]  port_c_pu_o,
   output logic             osc_amp_en_o,
   input  wire logic        spi_mosi_out_i,
   input  wire logic        spi_miso_out_i,
   input  wire logic        spi_clk_out_i,
   output logic             spi_mosi_in_o,
   output logic             spi_miso_in_o,
   output logic             spi_clk_in_o,
   output logic             spi_sel_n_o,
   output logic             spi_slave_act_o
);
   logic [7:0]  b_out_q;
   logic [7:0]  b_m1_q;
   logic [7:0]  b_m2_q;
   logic [7:0]  trim_q;
   logic [7:0]  b_in_q;
   logic [1:0]  c_out_q;
   logic [1:0]  c_in_q;
   logic [1:0]  c_m1_q;
   logic [1:0]  c_m2_q;
   logic        spi_en_q;
   logic        spi_mst_q;
   logic        xtal_q;
   logic        rtc_xtal_q;
   logic        div_q;
   pbm_clksrc_t clksrc_q;
   logic [7:0]  b_s1_q;
   logic [7:0]  b_s2_q;
   logic [7:0]  b_s3_q;
   logic [1:0]  c_s1_q;
   logic [1:0]  c_s2_q;
   logic [1:0]  c_s3_q;
   logic [7:0]  b_o_d;
   logic [7:0]  b_oe_d;
   logic [7:0]  b_pu_d;
   logic [1:0]  c_o_d;
   logic [1:0]  c_oe_d;
   logic [1:0]  c_pu_d;

   // Register index decode, shared by the read mux and the write chain
   wire sel_b_out  = (addr_i == PBM_A_B_OUT);
   wire sel_b_m1   = (addr_i == PBM_A_B_M1);
   wire sel_b_m2   = (addr_i == PBM_A_B_M2);
   wire sel_c_out  = (addr_i == PBM_A_C_OUT);
   wire sel_c_mode = (addr_i == PBM_A_C_MODE);
   wire sel_trim   = (addr_i == PBM_A_TRIM);
   wire sel_spi    = (addr_i == PBM_A_SPI);
   wire sel_clk    = (addr_i == PBM_A_CLK);
   wire sel_b_in   = (addr_i == PBM_A_B_IN);
   wire sel_c_in   = (addr_i == PBM_A_C_IN);

   // Pin drive from mode bits: returns {oe, pu} for a given output level
   function automatic logic [1:0] pbm_drive(input logic m1, input logic m2, input logic v);
      pbm_mode_t m;
      m = pbm_mode_t'({m1, m2});
      case (m)
         PBM_MODE_QUASI: pbm_drive = {~v, 1'b1};
         PBM_MODE_PUSH:  pbm_drive = 2'b10;
         PBM_MODE_OPEN:  pbm_drive = {~v, 1'b0};
         default:        pbm_drive = 2'b00;
      endcase
   endfunction : pbm_drive

   wire divided_clock_output_ok = trim_q[PBM_TRIM_CLKEN] && !rtc_xtal_q &&
                    (clksrc_q != PBM_CLK_XTAL) && !xtal_q;
   wire xin_free  = (clksrc_q == PBM_CLK_RC || clksrc_q == PBM_CLK_WDOG) && !rtc_xtal_q;
   wire slave_act = spi_en_q && !spi_mst_q && !b_in_q[4];
   wire spi_master = spi_en_q && spi_mst_q;
   wire [7:0] b_val = {b_out_q[7:6],
                       spi_master ? spi_clk_out_i : b_out_q[5],
                       b_out_q[4],
                       slave_act ? spi_miso_out_i : b_out_q[3],
                       spi_master ? spi_mosi_out_i : b_out_q[2],
                       b_out_q[1:0]};

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         {b_oe_d[i], b_pu_d[i]} = pbm_drive(b_m1_q[i], b_m2_q[i], b_val[i]);
         b_o_d[i] = b_val[i];
      end
      if (spi_master) begin
         b_oe_d[2] = 1'b1;
         b_oe_d[5] = 1'b1;
         b_oe_d[3] = 1'b0;
      end else if (spi_en_q) begin
         b_oe_d[2] = 1'b0;
         b_oe_d[5] = 1'b0;
         b_oe_d[3] = slave_act;
      end
      for (int j = 0; j < 2; j++) begin
         {c_oe_d[j], c_pu_d[j]} = pbm_drive(c_m1_q[j], c_m2_q[j], c_out_q[j]);
         c_o_d[j] = c_out_q[j];
      end
      if (xtal_q) begin
         {c_oe_d[0], c_pu_d[0], c_o_d[0]} = 3'b000;
      end else if (divided_clock_output_ok) begin
         {c_oe_d[0], c_pu_d[0], c_o_d[0]} = {2'b10, div_q};
      end
      if (!xin_free) begin
         {c_oe_d[1], c_pu_d[1], c_o_d[1]} = 3'b000;
      end
   end

   wire [7:0] rd_mux =
      sel_b_out  ? b_out_q :
      sel_b_m1   ? b_m1_q :
      sel_b_m2   ? b_m2_q :
      sel_c_out  ? {6'h00, c_out_q} :
      sel_c_mode ? {4'h0, c_m2_q, c_m1_q} :
      sel_trim   ? trim_q :
      sel_spi    ? {6'h00, spi_mst_q, spi_en_q} :
      sel_clk    ? {4'h0, rtc_xtal_q, xtal_q, clksrc_q} :
      sel_b_in   ? b_in_q :
      sel_c_in   ? {6'h00, c_in_q} : 8'h00;

   // Three-stage sync; value changes only when stages two and three agree
   // Holding on disagreement filters a one-cycle glitch at the cost of a cycle of latency
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         {b_s1_q, b_s2_q, b_s3_q, b_in_q} <= '0;
         {c_s1_q, c_s2_q, c_s3_q, c_in_q} <= '0;
      end else begin
         b_s1_q <= port_b_i;
         b_s2_q <= b_s1_q;
         b_s3_q <= b_s2_q;
         b_in_q <= (b_in_q & (b_s2_q ^ b_s3_q)) | (b_s2_q & b_s3_q);
         c_s1_q <= port_c_i;
         c_s2_q <= c_s1_q;
         c_s3_q <= c_s2_q;
         c_in_q <= (c_in_q & (c_s2_q ^ c_s3_q)) | (c_s2_q & c_s3_q);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         b_out_q  <= 8'h00;
         b_m1_q   <= {8{PBM_MODE_RESET[1]}};
         b_m2_q   <= {8{PBM_MODE_RESET[0]}};
         c_out_q  <= 2'h0;
         c_m1_q   <= {2{PBM_MODE_RESET[1]}};
         c_m2_q   <= {2{PBM_MODE_RESET[0]}};
         trim_q   <= PBM_TRIM_RESET;
         spi_en_q <= 1'b0;
         spi_mst_q <= 1'b0;
         clksrc_q <= PBM_CLK_RC;
         xtal_q   <= 1'b0;
         rtc_xtal_q <= 1'b0;
      end else if (wr_i) begin
         // Input indices are read only, so a write there falls through and is ignored
         if (sel_b_out) b_out_q <= wdata_i;
         else if (sel_b_m1) b_m1_q <= wdata_i;
         else if (sel_b_m2) b_m2_q <= wdata_i;
         else if (sel_c_out) c_out_q <= wdata_i[1:0];
         else if (sel_c_mode) {c_m2_q, c_m1_q} <= wdata_i[3:0];
         else if (sel_trim) trim_q <= wdata_i;
         else if (sel_spi) {spi_mst_q, spi_en_q} <= wdata_i[1:0];
         else if (sel_clk) begin
            clksrc_q   <= pbm_clksrc_t'(wdata_i[1:0]);
            xtal_q     <= wdata_i[2];
            rtc_xtal_q <= wdata_i[3];
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q <= 1'b0;
         rdata_o <= 8'h00;
         {port_b_o, port_b_oe_o, port_b_pu_o} <= '0;
         {port_c_o, port_c_oe_o, port_c_pu_o} <= '0;
         osc_amp_en_o <= 1'b0;
         {spi_mosi_in_o, spi_miso_in_o, spi_clk_in_o} <= 3'b000;
         spi_sel_n_o <= 1'b1;
         spi_slave_act_o <= 1'b0;
      end else begin
         div_q <= ~div_q;
         rdata_o <= rd_i ? rd_mux : 8'h00;
         port_b_o <= b_o_d;
         port_b_oe_o <= b_oe_d;
         port_b_pu_o <= b_pu_d;
         port_c_o <= c_o_d;
         port_c_oe_o <= c_oe_d;
         port_c_pu_o <= c_pu_d;
         osc_amp_en_o <= xtal_q;
         spi_mosi_in_o <= b_in_q[2];
         spi_miso_in_o <= b_in_q[3];
         spi_clk_in_o <= b_in_q[5];
         spi_sel_n_o <= b_in_q[4];
         spi_slave_act_o <= slave_act;
      end
   end
endmodule : pbm_pin_mux

// File: pbm_partner.sv
// Far-side model: pad levels and divided clock consumer
`timescale 1ns/1ps
module pbm_partner (
   input  wire logic [7:0] b_i,
   input  wire logic [7:0] boe_i,
   input  wire logic [7:0] bpu_i,
   input  wire logic [7:0] extb_i,
   input  wire logic [1:0] c_i,
   input  wire logic [1:0] coe_i,
   input  wire logic [1:0] extc_i,
   output logic      [7:0] padb_o,
   output logic      [1:0] padc_o,
   output int              rises_o = 0
);
   // Released pads without pull-up show the far-side level on extb_i or extc_i, redrawn at random every cycle
   assign padb_o = boe_i & b_i | ~boe_i & (bpu_i | extb_i);
   assign padc_o = coe_i & c_i | ~coe_i & extc_i;
   always @(posedge padc_o[0]) rises_o++;
endmodule : pbm_partner

// File: pbm_pin_mux_assertions.sv
// Assertion checker for the pin function mux
`timescale 1ns/1ps
module pbm_pin_mux_assertions
   import pbm_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic [7:0] port_b_i,
   input wire logic [7:0] port_b_oe_o,
   input wire logic [7:0] port_b_pu_o,
   input wire logic [1:0] port_c_o,
   input wire logic [1:0] port_c_oe_o,
   input wire logic [1:0] port_c_pu_o,
   input wire logic       osc_amp_en_o,
   input wire logic       spi_sel_n_o
);
   logic [1:0] spi_q;
   logic [3:0] clk_q;
   logic       ten_q;
   wire        cko = ten_q && clk_q[1:0] != 2'h3 && clk_q[3:2] == 2'h0;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Shadow of config writes, so pin checks need nothing from the body
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         spi_q <= 2'h0;
         clk_q <= 4'h0;
         ten_q <= 1'b0;
      end else if (wr_i) begin
         if (addr_i == PBM_A_SPI) spi_q <= wdata_i[1:0];
         if (addr_i == PBM_A_CLK) clk_q <= wdata_i[3:0];
         if (addr_i == PBM_A_TRIM) ten_q <= wdata_i[PBM_TRIM_CLKEN];
      end
   end
   sequence s_master; (spi_q == 2'h3) [*3]; endsequence
   sequence s_slave; (spi_q == 2'h1) [*3]; endsequence
   reset_input_a: assert property ($fell(rst_i) |->
      {port_b_oe_o, port_b_pu_o, port_c_oe_o, port_c_pu_o} == 20'h0_0000) else $error("reset mode");
   master_dir_a: assert property (s_master |-> port_b_oe_o[5] && port_b_oe_o[2] &&
      !port_b_oe_o[3])
      else $error("master directions");
   slave_dir_a: assert property (s_slave |-> !port_b_oe_o[2] && !port_b_oe_o[5])
      else $error("slave directions");
   select_feed_a: assert property (!port_b_i[4] [*8] |-> !spi_sel_n_o)
      else $error("select not fed");
   clock_out_a: assert property (cko [*4] |-> port_c_o[0] != $past(port_c_o[0]))
      else $error("clock out not toggling");
   clock_off_a: assert property ((ten_q && clk_q[2:0] == 3'h3 && !wr_i) [*4]
      |-> $stable(port_c_o[0])) else $error("clock out with crystal");
   amp_owns_a: assert property (clk_q[2] [*3] |-> osc_amp_en_o && !port_c_oe_o[0])
      else $error("amplifier pin");
   xin_free_a: assert property ((clk_q[1] || clk_q[3]) [*3]
      |-> !port_c_oe_o[1] && !port_c_pu_o[1]) else $error("oscillator input freed");
endmodule : pbm_pin_mux_assertions
bind pbm_pin_mux pbm_pin_mux_assertions pbm_pin_mux_assertions_i (.*);

// File: pbm_pin_mux_tb.sv
// Self-checking bench for the pin function mux
`timescale 1ns/1ps
module pbm_pin_mux_tb
   import pbm_pkg::*;
;
   logic       clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sel_lo = 1'b0;
   logic       spi_mosi_out_i = 1'b0, spi_miso_out_i = 1'b0, spi_clk_out_i = 1'b0;
   logic       osc_amp_en_o, spi_sel_n_o, spi_slave_act_o;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, ext_b = 8'h00, rdata_o, port_b_i, port_b_o, m1, m2, bo;
   logic [7:0] port_b_oe_o, port_b_pu_o;
   logic [1:0] ext_c = 2'h0, port_c_i, port_c_o, port_c_oe_o, port_c_pu_o;
   int         seed = 21, err_count = 0, samples_checked = 0, rises, r0;
   pbm_pin_mux pbm_pin_mux_i (.*, .spi_mosi_in_o(), .spi_miso_in_o(), .spi_clk_in_o());
   pbm_partner pbm_partner_i (.b_i(port_b_o), .boe_i(port_b_oe_o), .bpu_i(port_b_pu_o),
      .extb_i(ext_b), .c_i(port_c_o), .coe_i(port_c_oe_o), .extc_i(ext_c), .padb_o(port_b_i),
      .padc_o(port_c_i), .rises_o(rises));
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      ext_b <= 8'($random(seed)) & (sel_lo ? 8'hEF : 8'hFF);
      ext_c <= 2'($random(seed));
      {spi_mosi_out_i, spi_miso_out_i, spi_clk_out_i} <= 3'($random(seed));
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Waits for the pin flops to settle, so a check can follow the write directly
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk("rdata", e, rdata_o);
   endtask : rd
   task automatic span;
      r0 = rises;
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
   endtask : span
   task automatic test_done;
      if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   function automatic logic [7:0] pu_exp(input logic [7:0] a, input logic [7:0] b);
      return ~(a | b);
   endfunction : pu_exp
   initial begin
      #100_000;
      err_count++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("reset", 8'h00, port_b_oe_o | port_b_pu_o | {4'h0, port_c_oe_o, port_c_pu_o});
      sel_lo <= 1'b1;
      span();
      chk("sel_n", 8'h00, {7'h0, spi_sel_n_o});
      wr(PBM_A_SPI, 8'h03);
      chk("master_oe", 8'h24, port_b_oe_o & 8'h2C);
      wr(PBM_A_SPI, 8'h01);
      chk("slave_oe", 8'h08, port_b_oe_o & 8'h2C);
      chk("slave_act", 8'h01, {7'h0, spi_slave_act_o});
      sel_lo <= 1'b0;
      rd(4'hF, 8'h00);
      wr(PBM_A_SPI, 8'h00);
      for (int i = 0; i < 12; i++) begin
         m1 = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         m2 = (i < 2) ? ~m1 : 8'($random(seed));
         bo = 8'($random(seed));
         wr(PBM_A_B_M1, m1);
         wr(PBM_A_B_M2, m2);
         wr(PBM_A_B_OUT, bo);
         chk("b_pu", pu_exp(m1, m2), port_b_pu_o);
         chk("b_oe", m2 & (m1 ^ m2), port_b_oe_o & (m1 ^ m2));
         chk("b_out", bo & ~m1 & m2, port_b_o & ~m1 & m2);
      end
      wr(PBM_A_C_MODE, 8'h0C);
      wr(PBM_A_TRIM, 8'h40);
      rd(PBM_A_TRIM, 8'h40);
      span();
      chk("clk_out", 8'h0A, 8'(rises - r0));
      wr(PBM_A_CLK, 8'h03);
      span();
      chk("clk_off", 8'h00, 8'(rises - r0));
      chk("xin_oe", 8'h00, {7'h0, port_c_oe_o[1]});
      wr(PBM_A_CLK, 8'h04);
      chk("amp_xin", 8'h03, {6'h0, osc_amp_en_o, port_c_oe_o[1]});
      wr(PBM_A_CLK, 8'h08);
      chk("xin_oe", 8'h00, {7'h0, port_c_oe_o[1]});
      test_done();
   end
endmodule : pbm_pin_mux_tb
